// [include/gpio_port_consts.svh]
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH

// register word offsets (word index in bits 5:2 of the byte address on a 32-bit bus)
`define OFS_PIN_LEVEL       4'h0
`define OFS_PIN_DIRECTION   4'h1
`define OFS_OUTPUT_LATCH    4'h2
`define OFS_ANALOG_SELECT   4'h3
`define OFS_PULL_UP_ENABLE  4'h4
`define OFS_OPEN_DRAIN      4'h5
`define OFS_SLEW_LIMIT      4'h6
`define OFS_INPUT_THRESHOLD 4'h7

// reset values
`define RST_PIN_DIRECTION   8'hff
`define RST_OUTPUT_LATCH    8'h00
`define RST_ANALOG_SELECT   8'hff
`define RST_PULL_UP_ENABLE  8'h00
`define RST_OPEN_DRAIN      8'h00
`define RST_SLEW_LIMIT      8'hff
`define RST_INPUT_THRESHOLD 8'hff

`define WORD_IDX_LSB        2
`define WORD_IDX_MSB        5

`endif

// [include/gpio_port_pkg.sv]
package gpio_port_pkg;

    // per-pin controls driven by peripherals outside the port
    typedef struct packed {
        logic [7:0] periph_enable;
        logic [7:0] periph_out;
        logic [7:0] periph_oe;
        logic [7:0] periph_force_od;
        logic [7:0] analog_out_enable;
    } periph_ctl_t;

    // per-pin pad controls toward the pad cells
    typedef struct packed {
        logic [7:0] pull_up;
        logic [7:0] slew_limit;
        logic [7:0] schmitt;
        logic [7:0] input_buffer_enable;
    } pad_ctl_t;

endpackage

// [hdl/general_purpose_io_port.sv]
// Function
// - eight pins, one bit per pin
// - direction one disables driver, zero drives latch
// - pin level reads pins, writes latch
// - latch write equals pin write; reads latch
// - latch holds latest write from either
// - pin write replaces latch with written byte
// - analog select disables digital input buffer
// - analog pins read zero digitally
// - analog select leaves digital output alone
// - analog output overrides, forces high impedance
// - peripheral pin blocks port output, stays readable
// - reset output source is the latch
// - open drain sinks only, else push-pull
// - two-wire peripheral forces open drain
// - slew bit selects limited drive
// - threshold applies to reads and change detect
// - analog select resets to analog mode
// - one pull-up enable per pin
// - pull-up off while pin is output
// - threshold one Schmitt, zero TTL
`include "gpio_port_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module general_purpose_io_port
    import gpio_port_pkg::*;
#(
    parameter int PINS = 8
) (
    input  wire logic              mclk_in,
    input  wire logic              rst_n_in,
    input  wire logic [5:0]        avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [3:0]        avs_byteenable_in,
    input  wire logic [31:0]       avs_writedata_in,
    output logic      [31:0]       avs_readdata_out,
    output logic                   avs_waitrequest_out,
    input  wire periph_ctl_t       periph_in,
    input  wire logic [PINS-1:0]   port_pins_in,
    output logic      [PINS-1:0]   port_pins_out,
    output logic      [PINS-1:0]   port_pins_oe_out,
    output pad_ctl_t               pad_out,
    output logic      [PINS-1:0]   change_detect_out
);

    logic [PINS-1:0] pin_direction;
    logic [PINS-1:0] output_latch;
    logic [PINS-1:0] analog_select;
    logic [PINS-1:0] pull_up_enable;
    logic [PINS-1:0] open_drain_select;
    logic [PINS-1:0] slew_limit_select;
    logic [PINS-1:0] input_threshold_select;
    logic [PINS-1:0] pins_sampled;
    logic [PINS-1:0] pins_prev;
    logic            ack;
    logic [31:0]     rdata;

    // word decode shared by read and write paths
    function automatic logic hit(input logic [5:0] a, input logic [3:0] ofs);
        return a[`WORD_IDX_MSB:`WORD_IDX_LSB] == ofs && a[1:0] == 2'h0;
    endfunction

    wire logic       req       = avs_read_in | avs_write_in;
    wire logic       wr_go     = avs_write_in & ack & avs_byteenable_in[0];
    wire logic [7:0] wdata     = avs_writedata_in[7:0];
    wire logic       wr_level  = wr_go & hit(avs_address_in, `OFS_PIN_LEVEL);
    wire logic       wr_latch  = wr_go & hit(avs_address_in, `OFS_OUTPUT_LATCH);

    // digital input path: analog pins read zero, buffer off
    wire logic [PINS-1:0] digital_in = port_pins_in & ~analog_select;

    // output drive: peripheral owns pin, else latch; analog output wins
    wire logic [PINS-1:0] drive_val = (periph_in.periph_enable[PINS-1:0]
                                       & periph_in.periph_out[PINS-1:0])
                                    | (~periph_in.periph_enable[PINS-1:0]
                                       & output_latch);
    wire logic [PINS-1:0] drive_en  = (periph_in.periph_enable[PINS-1:0]
                                       & periph_in.periph_oe[PINS-1:0])
                                    | (~periph_in.periph_enable[PINS-1:0]
                                       & ~pin_direction);
    wire logic [PINS-1:0] od_mode   = open_drain_select
                                    | periph_in.periph_force_od[PINS-1:0];
    wire logic [PINS-1:0] oe_final  = drive_en & ~periph_in.analog_out_enable[PINS-1:0]
                                    & ~(od_mode & drive_val);

    // pad pin drive, per bit
    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_pin
            assign port_pins_out[i]    = od_mode[i] ? 1'b0 : drive_val[i];
            assign port_pins_oe_out[i] = oe_final[i];
        end
    endgenerate

    // pad controls
    assign pad_out.pull_up             = pull_up_enable & ~drive_en;
    assign pad_out.slew_limit          = slew_limit_select;
    assign pad_out.schmitt             = input_threshold_select;
    assign pad_out.input_buffer_enable = ~analog_select;
    assign change_detect_out           = pins_sampled ^ pins_prev;

    // read multiplexer
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit(avs_address_in, `OFS_PIN_LEVEL))       rdata[7:0] = pins_sampled;
        if (hit(avs_address_in, `OFS_PIN_DIRECTION))   rdata[7:0] = pin_direction;
        if (hit(avs_address_in, `OFS_OUTPUT_LATCH))    rdata[7:0] = output_latch;
        if (hit(avs_address_in, `OFS_ANALOG_SELECT))   rdata[7:0] = analog_select;
        if (hit(avs_address_in, `OFS_PULL_UP_ENABLE))  rdata[7:0] = pull_up_enable;
        if (hit(avs_address_in, `OFS_OPEN_DRAIN))      rdata[7:0] = open_drain_select;
        if (hit(avs_address_in, `OFS_SLEW_LIMIT))      rdata[7:0] = slew_limit_select;
        if (hit(avs_address_in, `OFS_INPUT_THRESHOLD)) rdata[7:0] = input_threshold_select;
    end

    // bus handshake: one wait state, then answer
    assign avs_waitrequest_out = req & ~ack;

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ack              <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            ack              <= req & ~ack;
            avs_readdata_out <= rdata;
        end
    end

    // input sampling
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            pins_sampled <= '0;
            pins_prev    <= '0;
        end else begin
            pins_sampled <= digital_in;
            pins_prev    <= pins_sampled;
        end
    end

    // output latch: latest of either write; byte write replaces all pins
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            output_latch <= `RST_OUTPUT_LATCH;
        end else if (wr_level | wr_latch) begin
            output_latch <= wdata;
        end
    end

    // control registers
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            pin_direction          <= `RST_PIN_DIRECTION;
            analog_select          <= `RST_ANALOG_SELECT;
            pull_up_enable         <= `RST_PULL_UP_ENABLE;
            open_drain_select      <= `RST_OPEN_DRAIN;
            slew_limit_select      <= `RST_SLEW_LIMIT;
            input_threshold_select <= `RST_INPUT_THRESHOLD;
        end else if (wr_go) begin
            if (hit(avs_address_in, `OFS_PIN_DIRECTION))   pin_direction <= wdata;
            if (hit(avs_address_in, `OFS_ANALOG_SELECT))   analog_select <= wdata;
            if (hit(avs_address_in, `OFS_PULL_UP_ENABLE))  pull_up_enable <= wdata;
            if (hit(avs_address_in, `OFS_OPEN_DRAIN))      open_drain_select <= wdata;
            if (hit(avs_address_in, `OFS_SLEW_LIMIT))      slew_limit_select <= wdata;
            if (hit(avs_address_in, `OFS_INPUT_THRESHOLD)) input_threshold_select <= wdata;
        end
    end

endmodule

`default_nettype wire

// [dv/gpio_port_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module gpio_port_monitor
    import gpio_port_pkg::*;
(
    input wire logic        mclk_in,
    input wire logic        rst_n_in,
    input wire logic [5:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire periph_ctl_t periph_in,
    input wire logic [7:0]  port_pins_out,
    input wire logic [7:0]  port_pins_oe_out,
    input wire pad_ctl_t    pad_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // a request waits one cycle, then is answered
    sequence s_ans; avs_waitrequest_out ##1 !avs_waitrequest_out; endsequence
    sequence s_lvl; avs_read_in && avs_address_in == 6'h00 && !avs_waitrequest_out; endsequence
    property p_wait; $rose(avs_read_in | avs_write_in) |-> s_ans; endproperty
    a_wait: assert property (p_wait) else $error("wait state wrong");
    property p_rd0; s_lvl |-> (avs_readdata_out[7:0] & ~pad_out.input_buffer_enable) == 0; endproperty
    a_rd0: assert property (p_rd0) else $error("analog pin read high");
    property p_aout; (periph_in.analog_out_enable & port_pins_oe_out) == 8'h00; endproperty
    a_aout: assert property (p_aout) else $error("analog out pin driven");
    property p_fod; (periph_in.periph_force_od & periph_in.periph_enable
        & port_pins_oe_out & port_pins_out) == 8'h00; endproperty
    a_fod: assert property (p_fod) else $error("two-wire pin driven high");
    property p_per; (((port_pins_out ^ periph_in.periph_out) | ~periph_in.periph_oe)
        & periph_in.periph_enable & port_pins_oe_out) == 8'h00; endproperty
    a_per: assert property (p_per) else $error("port drives peripheral pin");
    property p_pull; (pad_out.pull_up & port_pins_oe_out) == 8'h00; endproperty
    a_pull: assert property (p_pull) else $error("pull-up on output");
    property p_hi; avs_readdata_out[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");
    property p_rst; $rose(rst_n_in) |-> avs_readdata_out == 0 && pad_out == 32'h00ffff00
        && (port_pins_oe_out & ~periph_in.periph_enable) == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
`default_nettype wire

// [dv/pin_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pin_model (
    input wire logic [7:0] drive_in,
    input wire logic [7:0] oe_in,
    input wire logic [7:0] pull_in,
    input wire logic [7:0] ext_in,
    input wire logic [7:0] ext_en_in,
    input wire logic       clk_in,
    output logic     [7:0] pins_out
);
    logic [7:0] wob = 8'h55;
    // a floating line without pull-up flips every cycle
    always @(posedge clk_in) wob <= ~wob;
    // port driver first, then outside source, then pull-up
    assign pins_out = oe_in & drive_in | ~oe_in & (ext_en_in & ext_in | ~ext_en_in & (pull_in | wob));
endmodule
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench
    import gpio_port_pkg::*;
;
    logic mclk_in = 0, rst_n_in = 0, rd = 0, wr = 0, wt;
    logic [5:0] adr = 0;
    logic [3:0] be = 4'hf;
    logic [31:0] wdat = 0, rdat;
    logic [7:0] q, pins, pout, poe, chg, ext = 8'hff, ee = 8'hff;
    periph_ctl_t per = '0;
    pad_ctl_t pad;
    int mismatches = 0, n_compared = 0, cycles = 0;
    general_purpose_io_port i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(be), .avs_writedata_in(wdat),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wt), .periph_in(per), .port_pins_in(pins),
        .port_pins_out(pout), .port_pins_oe_out(poe), .pad_out(pad), .change_detect_out(chg));
    pin_model i_pins (.drive_in(pout), .oe_in(poe), .pull_in(pad.pull_up), .ext_in(ext),
        .ext_en_in(ee), .clk_in(mclk_in), .pins_out(pins));
    // clock and hang guard
    initial forever #25 mclk_in = ~mclk_in;
    always @(posedge mclk_in) if (++cycles == 3000) begin
        mismatches++;
        give_verdict();
    end
    task automatic give_verdict;
        if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // one transfer, held until the rising edge that sees waitrequest low
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] r);
        wr <= w;
        rd <= !w;
        adr <= a;
        wdat <= {24'h0, d};
        do @(posedge mclk_in); while (wt !== 1'b0);
        r = rdat[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic t_reset;
        logic [7:0] e [9] = '{0, 8'hff, 0, 8'hff, 0, 0, 8'hff, 8'hff, 0};
        for (int i = 0; i < 9; i++) begin
            bus(0, 6'(i * 4), 0, q);
            check("reset value", e[i], q);
        end
    endtask
    task automatic t_output;
        bus(1, 6'h0c, 0, q);
        bus(1, 6'h04, 0, q);
        bus(1, 6'h00, 8'h5a, q);
        bus(0, 6'h08, 0, q);
        check("latch", 8'h5a, q);
        check("oe", 8'hff, poe);
        bus(1, 6'h08, 8'ha5, q);
        bus(0, 6'h00, 0, q);
        check("pins", 8'ha5, q);
        be <= 4'he;
        bus(1, 6'h08, 0, q);
        be <= 4'hf;
        bus(1, 6'h10, 8'hff, q);
        check("pull-up", 8'h00, pad.pull_up);
        bus(1, 6'h04, 8'h0f, q);
        ee <= 8'h00;
        bus(0, 6'h00, 0, q);
        check("pins", 8'haf, q);
        ee <= 8'hff;
    endtask
    task automatic t_analog;
        bus(1, 6'h0c, 8'h0f, q);
        check("buffer", 8'hf0, pad.input_buffer_enable);
        bus(0, 6'h00, 0, q);
        check("pins", 8'ha0, q);
        bus(1, 6'h04, 0, q);
        check("oe", 8'hff, poe);
        bus(1, 6'h0c, 0, q);
    endtask
    task automatic t_od;
        bus(1, 6'h14, 8'hff, q);
        check("oe", 8'h5a, poe);
        check("high", 8'h00, pout & poe);
        bus(1, 6'h14, 0, q);
        bus(1, 6'h18, 0, q);
        check("slew", 8'h00, pad.slew_limit);
        bus(1, 6'h1c, 8'h3c, q);
        check("schmitt", 8'h3c, pad.schmitt);
    endtask
    task automatic t_periph;
        ext <= 8'h7f;
        per <= '{8'h03, 8'h00, 8'h03, 8'h02, 8'h80};
        repeat (2) @(posedge mclk_in);
        check("change", 8'h81, chg);
        check("oe", 8'h7f, poe);
        check("drive", 8'h24, pout & poe);
        bus(0, 6'h00, 0, q);
        check("pins", 8'h24, q);
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1;
        @(posedge mclk_in);
        t_reset();
        t_output();
        t_analog();
        t_od();
        t_periph();
        give_verdict();
    end
endmodule
bind general_purpose_io_port gpio_port_monitor i_mon (.*);
`default_nettype wire
